// ---- include/bpt_pkg.sv ----
// Purpose: shared constants, types and helpers for the bank close timing link
// Assumes: link clock is LINK_DIV system clocks; all bank timers count link clocks
// Notes: two-cycle command frame, first cycle with chip select high
package bpt_pkg;
    localparam int NUM_BANKS = 8;
    localparam int BANK_W = 3;
    localparam int CA_W = 6;
    localparam int FLAG_BIT = 5;  // all_bank_flag or auto_close_flag
    localparam int OP_W = 5;
    // link clock derived from the system clock
    localparam int SYS_PERIOD_PS = 20000;
    localparam int LINK_DIV = 8;
    localparam int LINK_HALF = LINK_DIV / 2;
    localparam int LINK_PERIOD_PS = SYS_PERIOD_PS * LINK_DIV;
    // analog minima turned into link clocks, rounded up, with clock floors
    localparam int RCD_NS = 18;
    localparam int RCD_MIN_CK = 4;
    localparam int RAS_NS = 42;
    localparam int RAS_MIN_CK = 3;
    localparam int RCD_RAW_CK = (RCD_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int RAS_RAW_CK = (RAS_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int RCD_CK = (RCD_RAW_CK > RCD_MIN_CK) ? RCD_RAW_CK : RCD_MIN_CK;
    localparam int RAS_CK = (RAS_RAW_CK > RAS_MIN_CK) ? RAS_RAW_CK : RAS_MIN_CK;
    localparam int RTP_CK = 8;     // read_to_close_clocks
    localparam int RPPB_CK = 4;    // single_bank_close_time
    localparam int RPAB_CK = 6;    // all_bank_close_time, kept above single
    localparam int WR_CK = 6;      // write_recovery_clocks
    localparam int WL_CK = 6;      // write_latency
    localparam int RC_CK = RAS_CK + RPPB_CK;
    localparam int BL_DEF = 16;
    localparam int BL_LONG = 32;
    localparam int BL32_EXTRA_CK = 8;
    localparam int RTP_START_OFS = 8;
    localparam int PREFETCH = 16;
    localparam int PF_CK = PREFETCH / 2;  // beats are double rate

    typedef logic [7:0] bpt_cnt_t;

    typedef enum logic [4:0] {
        BPT_OP_ACT = 5'h01,
        BPT_OP_RD  = 5'h02,
        BPT_OP_WR  = 5'h04,
        BPT_OP_MWR = 5'h06,
        BPT_OP_PRE = 5'h10
    } bpt_op_e;

    function automatic bpt_cnt_t bpt_max(input bpt_cnt_t a, input bpt_cnt_t b);
        return (a > b) ? a : b;
    endfunction

    function automatic bpt_cnt_t bpt_dec(input bpt_cnt_t a);
        return (a != 8'h00) ? a - 8'h01 : 8'h00;
    endfunction

    // round up to a whole number of prefetch groups
    function automatic bpt_cnt_t bpt_align(input bpt_cnt_t v);
        bpt_cnt_t u;
        u = bpt_cnt_t'(PF_CK);
        return ((v + u - 8'h01) / u) * u;
    endfunction
endpackage

// ---- include/bpt_link_if.sv ----
// Purpose: command/address link between controller and memory device
// Assumes: controller makes link_ck; device samples everything on its own clock
// Notes: single-direction link, no tri-state
`timescale 1ns/1ps
interface bpt_link_if;
    logic link_ck;
    logic cs;
    logic [5:0] ca;
    modport host (output link_ck, output cs, output ca);
    modport device (input link_ck, input cs, input ca);
endinterface

// ---- verilog/bpt_device.sv ----
// Purpose: device end: decodes the link, tracks bank state and closes banks
// Assumes: link pins asynchronous to clock; controller keeps its timing duties
// Notes: all bank timers step on each detected link clock rising edge
`timescale 1ns/1ps
module bpt_device
    import bpt_pkg::*;
#(
    parameter int BURST_LEN = BL_DEF
) (
    input wire logic clock,
    input wire logic sys_rst,
    bpt_link_if.device link,
    input wire logic err_clear,
    output logic [NUM_BANKS-1:0] bank_open,
    output logic [NUM_BANKS-1:0] bank_busy,
    output logic close_evt,
    output logic auto_evt,
    output logic [NUM_BANKS-1:0] close_mask,
    output logic proto_err
);
    // link synchroniser: pins pass two flops before any decode
    logic [7:0] s1_q, s1_d, s2_q, s2_d;
    logic ck_prev_q, ck_prev_d;
    logic rise;

    always_comb begin
        s1_d = {link.link_ck, link.cs, link.ca};
        s2_d = s1_q;
        ck_prev_d = s2_q[7];
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
            ck_prev_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            ck_prev_q <= ck_prev_d;
        end
    end

    assign rise = s2_q[7] & ~ck_prev_q;

    // command decoder: first frame cycle carries op and flag, second the bank
    logic phase_q, phase_d;
    logic [OP_W-1:0] op_q, op_d;
    logic flag_q, flag_d;
    logic exec;
    logic [BANK_W-1:0] bank;

    always_comb begin
        phase_d = phase_q;
        op_d = op_q;
        flag_d = flag_q;
        if (rise) begin
            if (!phase_q && s2_q[6]) begin
                phase_d = 1'b1;
                op_d = s2_q[OP_W-1:0];
                flag_d = s2_q[FLAG_BIT];
            end else begin
                phase_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            phase_q <= 1'b0;
            op_q <= 5'h00;
            flag_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            op_q <= op_d;
            flag_q <= flag_d;
        end
    end

    assign exec = rise & phase_q;
    assign bank = s2_q[BANK_W-1:0];

    // auto-close delays, fixed by burst length
    localparam bpt_cnt_t RD_AP_CK = bpt_cnt_t'((BURST_LEN == BL_LONG) ?
        BL32_EXTRA_CK + RTP_CK : RTP_CK);
    localparam bpt_cnt_t BURST_CK = bpt_cnt_t'(WL_CK + BURST_LEN / 2);

    // per-bank state: open flag, row-active lockout, close recovery, auto-close
    logic [NUM_BANKS-1:0] open_q, open_d, pend_q, pend_d;
    bpt_cnt_t ras_q [NUM_BANKS];
    bpt_cnt_t ras_d [NUM_BANKS];
    bpt_cnt_t rp_q [NUM_BANKS];
    bpt_cnt_t rp_d [NUM_BANKS];
    bpt_cnt_t ap_q [NUM_BANKS];
    bpt_cnt_t ap_d [NUM_BANKS];
    logic [NUM_BANKS-1:0] busy_d, cmask_d;
    logic cevt_d, aevt_d, err_d, bad;
    logic [NUM_BANKS-1:0] close_q, busy_q, cmask_q;
    logic cevt_q, aevt_q, err_q;

    always_comb begin
        open_d = open_q;
        pend_d = pend_q;
        cmask_d = '0;
        aevt_d = 1'b0;
        bad = 1'b0;
        for (int b = 0; b < NUM_BANKS; b++) begin
            ras_d[b] = ras_q[b];
            rp_d[b] = rp_q[b];
            ap_d[b] = ap_q[b];
        end
        if (rise) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                ras_d[b] = bpt_dec(ras_q[b]);
                rp_d[b] = bpt_dec(rp_q[b]);
                ap_d[b] = bpt_dec(ap_q[b]);
                // lockout holds the scheduled close until row-active is met;
                // fires on the rise that runs both counts out
                if (pend_q[b] && ap_d[b] == 8'h00 && ras_d[b] == 8'h00) begin
                    open_d[b] = 1'b0;
                    pend_d[b] = 1'b0;
                    rp_d[b] = bpt_cnt_t'(RPPB_CK);
                    cmask_d[b] = 1'b1;
                    aevt_d = 1'b1;
                end
            end
        end
        if (exec) begin
            unique case (op_q)
                BPT_OP_ACT: begin
                    // a row may open only in a closed, recovered bank
                    bad = open_q[bank] || rp_q[bank] > 8'h01;
                    open_d[bank] = 1'b1;
                    ras_d[bank] = bpt_cnt_t'(RAS_CK);
                end
                BPT_OP_RD, BPT_OP_WR, BPT_OP_MWR: begin
                    bad = !open_q[bank] || pend_q[bank];
                    // flag low keeps the bank open after the burst
                    pend_d[bank] = flag_q;
                    if (op_q == BPT_OP_RD) begin
                        ap_d[bank] = RD_AP_CK;
                    end else begin
                        // recovery waits for the last prefetch group
                        ap_d[bank] = bpt_align(BURST_CK) + 8'h01
                            + bpt_cnt_t'(WR_CK);
                    end
                end
                BPT_OP_PRE: begin
                    for (int b = 0; b < NUM_BANKS; b++) begin
                        if (flag_q || bank == BANK_W'(b)) begin
                            open_d[b] = 1'b0;
                            pend_d[b] = 1'b0;
                            rp_d[b] = bpt_cnt_t'(flag_q ? RPAB_CK : RPPB_CK);
                            cmask_d[b] = 1'b1;
                        end
                    end
                end
                default: bad = 1'b0;  // unknown ops are not this block's concern
            endcase
        end
        for (int b = 0; b < NUM_BANKS; b++) begin
            busy_d[b] = rp_d[b] != 8'h00;
        end
        cevt_d = |cmask_d;
        // a new fault wins over a clear in the same cycle
        err_d = bad | (err_q & ~err_clear);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            open_q <= '0;
            pend_q <= '0;
            for (int b = 0; b < NUM_BANKS; b++) begin
                ras_q[b] <= 8'h00;
                rp_q[b] <= 8'h00;
                ap_q[b] <= 8'h00;
            end
            close_q <= '0;
            busy_q <= '0;
            cmask_q <= '0;
            cevt_q <= 1'b0;
            aevt_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            open_q <= open_d;
            pend_q <= pend_d;
            for (int b = 0; b < NUM_BANKS; b++) begin
                ras_q[b] <= ras_d[b];
                rp_q[b] <= rp_d[b];
                ap_q[b] <= ap_d[b];
            end
            close_q <= open_d;
            busy_q <= busy_d;
            cmask_q <= cmask_d;
            cevt_q <= cevt_d;
            aevt_q <= aevt_d;
            err_q <= err_d;
        end
    end

    // outputs straight from flops; close_q mirrors open_q for the user side
    assign bank_open = close_q;
    assign bank_busy = busy_q;
    assign close_mask = cmask_q;
    assign close_evt = cevt_q;
    assign auto_evt = aevt_q;
    assign proto_err = err_q;
endmodule

// ---- verilog/bpt_host.sv ----
// Purpose: controller end: makes the link clock and issues only legal commands
// Assumes: one request at a time from the user side
// Notes: a request that is not yet legal simply waits; no refusal path
`timescale 1ns/1ps
module bpt_host
    import bpt_pkg::*;
#(
    parameter int BURST_LEN = BL_DEF
) (
    input wire logic clock,
    input wire logic sys_rst,
    bpt_link_if.host link,
    input wire logic req_valid,
    input wire logic [OP_W-1:0] req_op,
    input wire logic [BANK_W-1:0] req_bank,
    input wire logic req_flag,
    output logic req_ready,
    output logic req_ack
);
    typedef enum logic [1:0] {
        BPT_HS_IDLE = 2'b00,
        BPT_HS_LOAD = 2'b01,
        BPT_HS_C1   = 2'b10,
        BPT_HS_C2   = 2'b11
    } bpt_hs_e;

    localparam bpt_cnt_t RD_PRE_CK = bpt_max(bpt_cnt_t'(BURST_LEN / 2),
        bpt_cnt_t'(BURST_LEN / 2 - RTP_START_OFS + RTP_CK));
    localparam bpt_cnt_t WR_PRE_CK = bpt_cnt_t'(WL_CK + BURST_LEN / 2 + 1 + WR_CK);
    // a write auto-close waits for the last prefetch group, as the device does
    localparam bpt_cnt_t WR_AP_CK = bpt_align(bpt_cnt_t'(WL_CK + BURST_LEN / 2)) + 8'h01
        + bpt_cnt_t'(WR_CK);

    logic [2:0] div_q, div_d;
    logic ck_q, ck_d, fall, tick;
    bpt_hs_e st_q, st_d;
    logic [OP_W-1:0] op_q, op_d;
    logic [BANK_W-1:0] bank_q, bank_d;
    logic flag_q, flag_d, cs_q, cs_d, ack_q, ack_d, rdy_d, legal;
    logic [CA_W-1:0] ca_q, ca_d;
    logic [NUM_BANKS-1:0] open_q, open_d;
    bpt_cnt_t act_q [NUM_BANKS];
    bpt_cnt_t act_d [NUM_BANKS];
    bpt_cnt_t col_q [NUM_BANKS];
    bpt_cnt_t col_d [NUM_BANKS];
    bpt_cnt_t pre_q [NUM_BANKS];
    bpt_cnt_t pre_d [NUM_BANKS];
    bpt_cnt_t dly;

    assign fall = div_q == 3'(LINK_HALF - 1);
    assign tick = div_q == 3'(LINK_DIV - 1);

    // legality of the waiting request against the per-bank windows
    always_comb begin
        legal = 1'b0;
        unique case (req_op)
            BPT_OP_ACT: legal = !open_q[req_bank] && act_q[req_bank] == 8'h00;
            BPT_OP_RD, BPT_OP_WR, BPT_OP_MWR:
                legal = open_q[req_bank] && col_q[req_bank] == 8'h00;
            BPT_OP_PRE: begin
                legal = pre_q[req_bank] == 8'h00;
                if (req_flag) begin
                    for (int b = 0; b < NUM_BANKS; b++) begin
                        legal = legal && pre_q[b] == 8'h00;
                    end
                end
            end
            default: legal = 1'b0;
        endcase
    end

    // divider, frame sequencer and timing windows
    always_comb begin
        div_d = (div_q == 3'(LINK_DIV - 1)) ? 3'h0 : div_q + 3'h1;
        ck_d = div_d < 3'(LINK_HALF);
        st_d = st_q;
        op_d = op_q;
        bank_d = bank_q;
        flag_d = flag_q;
        cs_d = cs_q;
        ca_d = ca_q;
        ack_d = 1'b0;
        open_d = open_q;
        dly = 8'h00;
        for (int b = 0; b < NUM_BANKS; b++) begin
            act_d[b] = tick ? bpt_dec(act_q[b]) : act_q[b];
            col_d[b] = tick ? bpt_dec(col_q[b]) : col_q[b];
            pre_d[b] = tick ? bpt_dec(pre_q[b]) : pre_q[b];
        end
        unique case (st_q)
            BPT_HS_IDLE: begin
                if (req_valid && legal) begin
                    st_d = BPT_HS_LOAD;
                    op_d = req_op;
                    bank_d = req_bank;
                    flag_d = req_flag;
                    ack_d = 1'b1;
                end
            end
            BPT_HS_LOAD: begin
                if (fall) begin
                    st_d = BPT_HS_C1;
                    cs_d = 1'b1;
                    ca_d = {flag_q, op_q};
                    // windows start with the command's first clock edge
                    unique case (op_q)
                        BPT_OP_ACT: begin
                            open_d[bank_q] = 1'b1;
                            col_d[bank_q] = bpt_cnt_t'(RCD_CK);
                            pre_d[bank_q] = bpt_cnt_t'(RAS_CK);
                            act_d[bank_q] = bpt_cnt_t'(RC_CK);
                        end
                        BPT_OP_RD, BPT_OP_WR, BPT_OP_MWR: begin
                            // read window starts half burst minus eight after
                            dly = (op_q == BPT_OP_RD) ? RD_PRE_CK : WR_PRE_CK;
                            pre_d[bank_q] = bpt_max(pre_q[bank_q], dly);
                            if (flag_q) begin
                                open_d[bank_q] = 1'b0;
                                act_d[bank_q] = bpt_max(act_q[bank_q], bpt_cnt_t'(RPPB_CK)
                                    + bpt_max(pre_q[bank_q],
                                    (op_q == BPT_OP_RD) ? dly : WR_AP_CK));
                            end
                        end
                        BPT_OP_PRE: begin
                            for (int b = 0; b < NUM_BANKS; b++) begin
                                if (flag_q || bank_q == BANK_W'(b)) begin
                                    open_d[b] = 1'b0;
                                    // all-bank close takes the longer count
                                    act_d[b] = bpt_max(act_q[b], bpt_cnt_t'(flag_q ?
                                        RPAB_CK : RPPB_CK));
                                end
                            end
                        end
                        default: open_d = open_q;
                    endcase
                end
            end
            BPT_HS_C1: begin
                if (fall) begin
                    st_d = BPT_HS_C2;
                    cs_d = 1'b0;
                    ca_d = {3'h0, bank_q};
                end
            end
            BPT_HS_C2: begin
                if (fall) begin
                    st_d = BPT_HS_IDLE;
                    ca_d = 6'h00;
                end
            end
        endcase
        rdy_d = st_d == BPT_HS_IDLE;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            div_q <= 3'h7;  // wraps to zero first, so the first high phase is full length
            ck_q <= 1'b0;
            st_q <= BPT_HS_IDLE;
            op_q <= 5'h00;
            bank_q <= 3'h0;
            flag_q <= 1'b0;
            cs_q <= 1'b0;
            ca_q <= 6'h00;
            ack_q <= 1'b0;
            req_ready <= 1'b0;
            open_q <= '0;
            for (int b = 0; b < NUM_BANKS; b++) begin
                act_q[b] <= 8'h00;
                col_q[b] <= 8'h00;
                pre_q[b] <= 8'h00;
            end
        end else begin
            div_q <= div_d;
            ck_q <= ck_d;
            st_q <= st_d;
            op_q <= op_d;
            bank_q <= bank_d;
            flag_q <= flag_d;
            cs_q <= cs_d;
            ca_q <= ca_d;
            ack_q <= ack_d;
            req_ready <= rdy_d;
            open_q <= open_d;
            for (int b = 0; b < NUM_BANKS; b++) begin
                act_q[b] <= act_d[b];
                col_q[b] <= col_d[b];
                pre_q[b] <= pre_d[b];
            end
        end
    end

    assign link.link_ck = ck_q;
    assign link.cs = cs_q;
    assign link.ca = ca_q;
    assign req_ack = ack_q;
endmodule

// ---- dv/bpt_link_properties.sv ----
// Purpose: watches the command link between the two ends for framing and timing slips
// Assumes: sees only the link wires plus the system clock and reset
// Notes: link timing is checked in system clocks, LINK_DIV of them per link clock
`timescale 1ns/1ps
module bpt_link_properties
    import bpt_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic link_ck,
    input wire logic cs,
    input wire logic [5:0] ca
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // link clock halves: four system clocks each, so the device edge finder never misses one
    a_link_high_time: assert property ($rose(link_ck) |-> link_ck[*4] ##1 !link_ck)
        else $error("link clock high phase wrong length");
    a_link_low_time: assert property ($fell(link_ck) |-> !link_ck[*4] ##1 link_ck)
        else $error("link clock low phase wrong length");
    // select marks exactly one link cycle, and a frame always has a select-low second cycle
    a_cs_one_cycle: assert property ($rose(cs) |-> cs[*8] ##1 !cs)
        else $error("select not held for one link cycle");
    a_cs_low_gap: assert property ($fell(cs) |-> !cs[*8])
        else $error("select raised again inside a frame");
    // wires move only while the link clock is low, away from the sampling rise
    a_cs_moves_low: assert property ($changed(cs) |-> !link_ck)
        else $error("select changed while link clock high");
    a_ca_moves_low: assert property ($changed(ca) |-> !link_ck)
        else $error("command lines changed while link clock high");
    a_cs_meets_rise: assert property ($rose(cs) |-> ##[1:4] $rose(link_ck))
        else $error("no link clock rise after select");
    // first cycle carries a known command, second cycle only the bank number
    a_frame_op_legal: assert property (cs |-> ca[4:0] inside {BPT_OP_ACT, BPT_OP_RD,
        BPT_OP_WR, BPT_OP_MWR, BPT_OP_PRE})
        else $error("unknown command code on link");
    a_bank_cycle_form: assert property ($fell(cs) |-> ca[5:3] == 3'h0)
        else $error("upper lines not zero in bank cycle");
endmodule

// ---- dv/bpt_tb_top.sv ----
// Purpose: drives the controller end and checks what the device end makes of the link
// Assumes: both ends back to back; the controller keeps every timing window itself
// Notes: delays are measured from the select rise of a frame, so divider phase drops out
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module bpt_tb_top
    import bpt_pkg::*;
;
    localparam int BURST = BL_DEF;
    localparam int WAP = ((WL_CK + BURST / 2 + PF_CK - 1) / PF_CK) * PF_CK + 1 + WR_CK;
    localparam int LIMIT = 60000;  // whole run needs well under half of this
    typedef struct {
        logic [4:0] op;
        logic [2:0] bank;
        logic flag;
        int ext;  // extra link clocks before the close, -1 when none is due
        logic [7:0] mask;
        logic ac;
        logic [7:0] open;
    } bpt_row_s;
    bpt_row_s rows [11];
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    logic [OP_W-1:0] req_op = 5'h00;
    logic [BANK_W-1:0] req_bank = 3'h0;
    logic req_flag = 1'b0;
    logic err_clear = 1'b0;
    logic req_ready, req_ack, close_evt, auto_evt, proto_err;
    logic [NUM_BANKS-1:0] bank_open, bank_busy, close_mask;
    int num_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int cs_t = 0;
    int close_t = 0;
    int n_close = 0;
    int busy0 = 0;
    logic cs_q = 1'b0;
    logic [7:0] last_mask;
    logic last_ac;

    initial begin
        forever #10 clock = ~clock;
    end

    bpt_link_if link ();
    bpt_host #(.BURST_LEN(BURST)) i_bpt_host (.clock(clock), .sys_rst(sys_rst),
        .link(link.host), .req_valid(req_valid), .req_op(req_op), .req_bank(req_bank),
        .req_flag(req_flag), .req_ready(req_ready), .req_ack(req_ack));
    bpt_device #(.BURST_LEN(BURST)) i_bpt_device (.clock(clock), .sys_rst(sys_rst),
        .link(link.device), .err_clear(err_clear), .bank_open(bank_open),
        .bank_busy(bank_busy), .close_evt(close_evt), .auto_evt(auto_evt),
        .close_mask(close_mask), .proto_err(proto_err));
    bpt_link_properties i_bpt_link_properties (.clock(clock), .sys_rst(sys_rst),
        .link_ck(link.link_ck), .cs(link.cs), .ca(link.ca));

    // sampled mid-cycle so flop outputs are settled and never raced
    always @(negedge clock) begin
        cyc++;
        if (link.cs === 1'b1 && cs_q !== 1'b1) begin
            cs_t = cyc;
        end
        cs_q = link.cs;
        if (close_evt === 1'b1) begin
            n_close++;
            close_t = cyc;
            last_mask = close_mask;
            last_ac = auto_evt;
        end
        if (bank_busy[0] === 1'b1) begin
            busy0++;
        end
        if (cyc > LIMIT) begin
            num_errors++;
            results();
        end
    end

    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // request held until taken, then released; returns once the frame has gone out
    task automatic issue(input logic [4:0] op, input logic [2:0] b, input logic f);
        @(posedge clock);
        #1;
        req_valid = 1'b1;
        req_op = op;
        req_bank = b;
        req_flag = f;
        do begin
            @(posedge clock);
            #1;
        end while (req_ack !== 1'b1);
        req_valid = 1'b0;
        while (req_ready !== 1'b1) begin
            @(posedge clock);
            #1;
        end
    endtask

    task automatic close_wait(input int n0);
        while (n_close == n0) begin
            @(posedge clock);
        end
        #1;
    endtask

    initial begin
        int base;
        int t0;
        int busy_ab;
        int n0;
        rows = '{'{BPT_OP_ACT, 3'h3, 1'b0, -1, 8'h00, 1'b0, 8'h08},
                 '{BPT_OP_ACT, 3'h6, 1'b0, -1, 8'h00, 1'b0, 8'h48},
                 '{BPT_OP_RD, 3'h3, 1'b0, -1, 8'h00, 1'b0, 8'h48},
                 '{BPT_OP_WR, 3'h6, 1'b0, -1, 8'h00, 1'b0, 8'h48},
                 '{BPT_OP_MWR, 3'h6, 1'b0, -1, 8'h00, 1'b0, 8'h48},
                 '{BPT_OP_PRE, 3'h3, 1'b0, 0, 8'h08, 1'b0, 8'h40},
                 '{BPT_OP_ACT, 3'h3, 1'b0, -1, 8'h00, 1'b0, 8'h48},
                 '{BPT_OP_RD, 3'h3, 1'b1, RTP_CK, 8'h08, 1'b1, 8'h40},
                 '{BPT_OP_WR, 3'h6, 1'b1, WAP, 8'h40, 1'b1, 8'h00},
                 '{BPT_OP_ACT, 3'h6, 1'b0, -1, 8'h00, 1'b0, 8'h40},
                 '{BPT_OP_MWR, 3'h6, 1'b1, WAP, 8'h40, 1'b1, 8'h00}};
        repeat (5) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        repeat (2) @(posedge clock);
        base = 0;
        // ordinary traffic; the first plain close sets the reference delay
        foreach (rows[i]) begin
            n0 = n_close;
            issue(rows[i].op, rows[i].bank, rows[i].flag);
            if (rows[i].ext >= 0) begin
                close_wait(n0);
                if (rows[i].ext == 0) begin
                    base = close_t - cs_t;
                end
                `CHK("close_mask", rows[i].mask, last_mask)
                `CHK("auto_evt", rows[i].ac, last_ac)
                `CHK("close_delay", base + rows[i].ext * LINK_DIV, close_t - cs_t)
            end else begin
                repeat (16) @(posedge clock);
                #1;
                `CHK("no_close", n0, n_close)
            end
            `CHK("bank_open", rows[i].open, bank_open)
        end
        // reopening bank 6 right after its write auto-close must not be early
        `CHK("rows_err", 1'b0, proto_err)
        // every bank number, then an all-bank close whose bank bits must be ignored
        for (int b = 0; b < NUM_BANKS; b++) begin
            issue(BPT_OP_ACT, 3'(b), 1'b0);
        end
        repeat (16) @(posedge clock);
        #1;
        `CHK("all_open", 8'hff, bank_open)
        busy0 = 0;
        n0 = n_close;
        issue(BPT_OP_PRE, 3'h5, 1'b1);
        close_wait(n0);
        `CHK("all_mask", 8'hff, last_mask)
        repeat (200) @(posedge clock);
        busy_ab = busy0;
        // reopen right after a single-bank and an all-bank close: controller must hold off
        issue(BPT_OP_ACT, 3'h0, 1'b0);
        issue(BPT_OP_PRE, 3'h0, 1'b0);
        t0 = cs_t;
        issue(BPT_OP_ACT, 3'h0, 1'b0);
        `CHK("reopen_gap", 1'b1, (cs_t - t0) >= RPPB_CK * LINK_DIV)
        busy0 = 0;
        issue(BPT_OP_PRE, 3'h0, 1'b0);
        repeat (200) @(posedge clock);
        `CHK("busy_diff", (RPAB_CK - RPPB_CK) * LINK_DIV, busy_ab - busy0)
        issue(BPT_OP_ACT, 3'h1, 1'b0);
        issue(BPT_OP_PRE, 3'h0, 1'b1);
        t0 = cs_t;
        issue(BPT_OP_ACT, 3'h1, 1'b0);
        `CHK("reopen_all_gap", 1'b1, (cs_t - t0) >= RPAB_CK * LINK_DIV)
        `CHK("proto_err", 1'b0, proto_err)
        // reset in mid-run with a bank open: state must clear and the link restart
        @(posedge clock);
        #1;
        sys_rst = 1'b1;
        err_clear = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        `CHK("rst_open", 8'h00, bank_open)
        `CHK("rst_ready", 1'b0, req_ready)
        sys_rst = 1'b0;
        err_clear = 1'b0;
        @(posedge clock);
        #1;
        `CHK("ready_after_rst", 1'b1, req_ready)
        issue(BPT_OP_ACT, 3'h2, 1'b0);
        repeat (16) @(posedge clock);
        #1;
        `CHK("open_after_rst", 8'h04, bank_open)
        results();
    end
endmodule
